// >>> rtl/rfat_pkg.sv
// Purpose: Constants, types and helpers for the ATTRIB command handler.
// Assumes: 50 MHz system clock; subcarrier frequency fs of 848 kHz.
// Notes: CRC helper is the reflected CCITT form used for CRC_B framing.
//
// What this block does
// - Request is code 0x1D, 4-byte identifier, four parameter bytes, 2-byte CRC.
// - Param1 bits 7-6 pick response delay; 11b folds to 00b; always wait 64/fs.
// - Param1 bits 5-4 pick subcarrier-to-data time; 11b folds to 00b; apply 80/fs.
// - Param1 bit 3 asks to drop EOF; tag always sends EOF anyway.
// - Param1 bit 2 asks to drop SOF; tag always sends SOF; bits 1-0 ignored.
// - Param2 bits 7-6 and 5-4 select rates: 00b 106 Kbps, 01b 212 Kbps.
// - Unequal rate selections in param2 mean no answer.
// - Param2 bits 3-0 give reader frame size: 8=256, 7=128, 6=96, 5=64 bytes.
// - Any unsupported param2 code means no answer.
// - Param3 must be 0x01: upper nibble zero, lower nibble the protocol type.
// - Any other param3 value means no answer.
// - Param4 bits 7-4 ignored; answer only when bits 3-0 are zero.
// - CRC_B is checked over every preceding byte of the frame.
// - Valid request enters command-enabled state and adopts agreed settings.
// - Answer is byte 0x10 followed by its CRC_B.
package rfat_pkg;

  localparam longint CLK_HZ = 50_000_000;
  localparam longint FS_HZ = 848_000;
  // Times in units of 1/fs
  localparam longint TR0_MIN_FS = 64;
  localparam longint TR1_MIN_FS = 80;
  // Least times round up to whole cycles
  localparam int TR0_CYCLES = int'((TR0_MIN_FS * CLK_HZ + FS_HZ - 1) / FS_HZ);
  localparam int TR1_CYCLES_DFLT = int'((TR1_MIN_FS * CLK_HZ + FS_HZ - 1) / FS_HZ);

  localparam logic [7:0] CMD_ATTRIB = 8'h1D;
  localparam logic [7:0] RESP_CODE = 8'h10;
  localparam logic [3:0] PROTO_TYPE_DFLT = 4'h1;
  localparam int FRAME_LEN = 11;
  localparam int CRC_POS = 9;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h8408;

  localparam logic [1:0] RATE_106 = 2'h0;
  localparam logic [1:0] RATE_212 = 2'h1;
  localparam logic [3:0] FSIZE_MIN = 4'h5;
  localparam logic [3:0] FSIZE_MAX = 4'h8;
  localparam logic [1:0] P1_RFU = 2'h3;

  // Register byte offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_PUPI = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_COUNT = 4'hC;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam logic [31:0] PUPI_RESET = 32'h0000_0000;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_CLEAR_BIT = 1;
  localparam int ST_ACTIVE_BIT = 0;
  localparam int ST_RATE_LSB = 1;
  localparam int ST_FSIZE_LSB = 3;
  localparam int ST_TR0_LSB = 7;
  localparam int ST_TR1_LSB = 9;
  localparam int ST_BUSY_BIT = 11;
  localparam int CNT_REJ_LSB = 8;

  typedef enum {ST_IDLE, ST_TR0, ST_TR1, ST_SEND} rfat_tx_state_t;

  function automatic logic [15:0] rfat_crc_byte(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc ^ {8'h00, data};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  localparam logic [15:0] RESP_CRC = ~rfat_crc_byte(CRC_INIT, RESP_CODE);

endpackage

// >>> rtl/rfat_crc_if.sv
// Purpose: Carries the running CRC_B between the frame parser and its engine.
// Assumes: One byte per update, on the system clock.
// Notes: Value is the raw register; the frame holds its complement.
interface rfat_crc_if;
  logic clear;
  logic update;
  logic [7:0] data;
  logic [15:0] value;
  modport engine (input clear, input update, input data, output value);
  modport user (output clear, output update, output data, input value);
endinterface

// >>> rtl/rfat_crc.sv
// Purpose: Byte-wide CRC_B accumulator.
// Assumes: Clear and update are never needed in the same cycle.
// Notes: Clear takes precedence over update.
module rfat_crc (
  input wire logic clock,
  input wire logic rst_n,
  rfat_crc_if.engine crc
);
  import rfat_pkg::*;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      crc.value <= CRC_INIT;
    end else if (crc.clear) begin
      crc.value <= CRC_INIT;
    end else if (crc.update) begin
      crc.value <= rfat_crc_byte(crc.value, crc.data);
    end
  end
endmodule

// >>> rtl/rfat_attrib_handler.sv
// Purpose: Parses ATTRIB frames, answers valid ones and holds the agreed settings.
// Assumes: Receive bytes and transmit handshake come from same-clock link logic.
// Notes: Registers over Avalon-MM with one wait state on every access.
//
// The implementer's own choices: the register offsets and the Avalon-MM interface to the registers.
module rfat_attrib_handler #(
  parameter int TR1_CYCLES = rfat_pkg::TR1_CYCLES_DFLT,
  parameter logic [3:0] PROTO_TYPE = rfat_pkg::PROTO_TYPE_DFLT
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  input wire logic rxEnd,
  output logic subcarrierOn,
  output logic txValid,
  output logic [7:0] txData,
  output logic txLast,
  input wire logic txReady,
  output logic txSofEnable,
  output logic txEofEnable,
  output logic [1:0] linkRate,
  output logic cmdEnabled
);
  import rfat_pkg::*;

  if (TR1_CYCLES < 1 || TR1_CYCLES > 65535) begin : g_bad_tr1
    $error("TR1_CYCLES must lie in 1..65535");
  end
  if (PROTO_TYPE != PROTO_TYPE_DFLT) begin : g_bad_proto
    $error("PROTO_TYPE must match the protocol type the tag reports");
  end
  if (FRAME_LEN > 15 || CRC_POS != FRAME_LEN - 2) begin : g_bad_frame
    $error("Frame layout does not fit the byte counter");
  end

  function automatic logic [1:0] foldRfu(input logic [1:0] code);
    return (code == P1_RFU) ? 2'h0 : code;
  endfunction

  function automatic logic rateSupported(input logic [1:0] code);
    return (code == RATE_106) || (code == RATE_212);
  endfunction

  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Register state
  logic [31:0] ctrl;
  logic [31:0] pupi;
  logic busAck;
  logic wrStrobe;
  logic [7:0] acceptCnt;
  logic [7:0] rejectCnt;

  // Agreed settings
  logic [3:0] frameSize;
  logic [1:0] tr0Code;
  logic [1:0] tr1Code;

  // Receive state
  logic [7:0] frame [FRAME_LEN];
  logic [3:0] byteCnt;
  logic overrun;

  // Transmit state
  rfat_tx_state_t txState;
  logic [15:0] waitCnt;
  logic [1:0] txIdx;

  rfat_crc_if crcBus ();

  rfat_crc u_crc (
    .clock(clock),
    .rst_n(rst_n),
    .crc(crcBus)
  );

  // Bus slave: one wait state, then answer
  assign avs_waitrequest = (avs_read | avs_write) & ~busAck;
  assign wrStrobe = avs_write & busAck;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busAck <= 1'b0;
    end else begin
      busAck <= (avs_read | avs_write) & ~busAck;
    end
  end

  // Address decode shared by reads, writes and the clear strobe
  logic selCtrl;
  logic selPupi;
  logic selStatus;
  logic selCount;
  assign selCtrl = avs_address == REG_CTRL;
  assign selPupi = avs_address == REG_PUPI;
  assign selStatus = avs_address == REG_STATUS;
  assign selCount = avs_address == REG_COUNT;

  // Read word assembled from the field positions
  logic [31:0] next_readdata;
  always_comb begin
    next_readdata = 32'h0000_0000;
    if (selCtrl) begin
      next_readdata[CTRL_ENABLE_BIT] = ctrl[CTRL_ENABLE_BIT];
    end else if (selPupi) begin
      next_readdata = pupi;
    end else if (selStatus) begin
      next_readdata[ST_ACTIVE_BIT] = cmdEnabled;
      next_readdata[ST_RATE_LSB +: 2] = linkRate;
      next_readdata[ST_FSIZE_LSB +: 4] = frameSize;
      next_readdata[ST_TR0_LSB +: 2] = tr0Code;
      next_readdata[ST_TR1_LSB +: 2] = tr1Code;
      next_readdata[ST_BUSY_BIT] = txState != ST_IDLE;
    end else if (selCount) begin
      next_readdata[7:0] = acceptCnt;
      next_readdata[CNT_REJ_LSB +: 8] = rejectCnt;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !busAck) begin
      avs_readdata <= next_readdata;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= CTRL_RESET;
      pupi <= PUPI_RESET;
    end else if (wrStrobe) begin
      if (selCtrl) begin
        ctrl <= mergeBytes(ctrl, avs_writedata, avs_byteenable);
      end else if (selPupi) begin
        pupi <= mergeBytes(pupi, avs_writedata, avs_byteenable);
      end
    end
  end

  logic clearReq;
  assign clearReq = wrStrobe && selCtrl && avs_byteenable[0] && avs_writedata[CTRL_CLEAR_BIT];

  // Frame collection
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      byteCnt <= 4'h0;
      overrun <= 1'b0;
      for (int i = 0; i < FRAME_LEN; i++) begin
        frame[i] <= 8'h00;
      end
    end else if (rxEnd) begin
      byteCnt <= 4'h0;
      overrun <= 1'b0;
    end else if (rxValid) begin
      if (int'(byteCnt) < FRAME_LEN) begin
        frame[byteCnt] <= rxData;
        byteCnt <= byteCnt + 4'h1;
      end else begin
        overrun <= 1'b1;
      end
    end
  end

  assign crcBus.clear = rxEnd;
  assign crcBus.update = rxValid && !rxEnd && (int'(byteCnt) < CRC_POS);
  assign crcBus.data = rxData;

  // Frame checks
  logic lenOk;
  logic cmdOk;
  logic idOk;
  logic crcOk;
  logic rateOk;
  logic sizeOk;
  logic p3Ok;
  logic p4Ok;
  logic frameOk;
  logic attribOk;
  logic frameRejected;

  assign lenOk = (int'(byteCnt) == FRAME_LEN) && !overrun;
  assign cmdOk = frame[0] == CMD_ATTRIB;
  assign idOk = {frame[1], frame[2], frame[3], frame[4]} == pupi;
  assign crcOk = {frame[10], frame[9]} == ~crcBus.value;
  assign rateOk = (frame[6][7:6] == frame[6][5:4])
                  && rateSupported(frame[6][7:6])
                  && rateSupported(frame[6][5:4]);
  assign sizeOk = (frame[6][3:0] >= FSIZE_MIN) && (frame[6][3:0] <= FSIZE_MAX);
  assign p3Ok = frame[7] == {4'h0, PROTO_TYPE};
  assign p4Ok = frame[8][3:0] == 4'h0;
  assign frameOk = lenOk && cmdOk && idOk && crcOk && rateOk && sizeOk && p3Ok && p4Ok;
  assign attribOk = rxEnd && ctrl[CTRL_ENABLE_BIT] && (txState == ST_IDLE) && frameOk;
  assign frameRejected = rxEnd && (byteCnt != 4'h0) && !attribOk;

  // Command-enabled state; a new acceptance wins over a clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cmdEnabled <= 1'b0;
    end else if (attribOk) begin
      cmdEnabled <= 1'b1;
    end else if (clearReq) begin
      cmdEnabled <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      linkRate <= RATE_106;
      frameSize <= FSIZE_MAX;
      tr0Code <= 2'h0;
      tr1Code <= 2'h0;
    end else if (attribOk) begin
      linkRate <= frame[6][7:6];
      frameSize <= frame[6][3:0];
      tr0Code <= foldRfu(frame[5][7:6]);
      tr1Code <= foldRfu(frame[5][5:4]);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      acceptCnt <= 8'h00;
      rejectCnt <= 8'h00;
    end else begin
      if (attribOk) begin
        acceptCnt <= acceptCnt + 8'h01;
      end
      if (frameRejected) begin
        rejectCnt <= rejectCnt + 8'h01;
      end
    end
  end

  // Framing markers are never omitted, whatever param1 asks
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      txSofEnable <= 1'b1;
      txEofEnable <= 1'b1;
    end else begin
      txSofEnable <= 1'b1;
      txEofEnable <= 1'b1;
    end
  end

  // Answer sequencer
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      txState <= ST_IDLE;
      waitCnt <= 16'h0000;
      subcarrierOn <= 1'b0;
      txValid <= 1'b0;
      txData <= 8'h00;
      txLast <= 1'b0;
      txIdx <= 2'h0;
    end else begin
      case (txState)
        ST_IDLE: begin
          if (attribOk) begin
            txState <= ST_TR0;
            waitCnt <= 16'(TR0_CYCLES - 1);
          end
        end
        ST_TR0: begin
          if (waitCnt == 16'h0000) begin
            txState <= ST_TR1;
            subcarrierOn <= 1'b1;
            waitCnt <= 16'(TR1_CYCLES - 1);
          end else begin
            waitCnt <= waitCnt - 16'h0001;
          end
        end
        ST_TR1: begin
          if (waitCnt == 16'h0000) begin
            txState <= ST_SEND;
            txValid <= 1'b1;
            txData <= RESP_CODE;
            txLast <= 1'b0;
            txIdx <= 2'h0;
          end else begin
            waitCnt <= waitCnt - 16'h0001;
          end
        end
        ST_SEND: begin
          if (txReady) begin
            if (txIdx == 2'h0) begin
              txData <= RESP_CRC[7:0];
              txIdx <= 2'h1;
            end else if (txIdx == 2'h1) begin
              txData <= RESP_CRC[15:8];
              txLast <= 1'b1;
              txIdx <= 2'h2;
            end else begin
              txValid <= 1'b0;
              txLast <= 1'b0;
              txData <= 8'h00;
              subcarrierOn <= 1'b0;
              txState <= ST_IDLE;
            end
          end
        end
        default: begin
          txState <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// >>> verif/rfat_pcd_model.sv
// Purpose: Reader-side model that sends ATTRIB frames and takes the answer bytes.
// Assumes: Same clock as the handler; one byte per cycle.
// Notes: With stall high, txReady drops every other cycle.
module rfat_pcd_model (
  input wire logic clock,
  input wire logic stall,
  input wire logic txValid,
  input wire logic [7:0] txData,
  output logic rxValid,
  output logic [7:0] rxData,
  output logic rxEnd,
  output logic txReady
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got[$];
  initial begin
    rxValid = 1'b0;
    rxData = 8'h00;
    rxEnd = 1'b0;
    txReady = 1'b0;
  end
  always @(posedge clock) begin
    if (txValid && txReady) got.push_back(txData);
    txReady <= stall ? !txReady : 1'b1;
  end
  task automatic send(input logic [31:0] id, input logic [31:0] prm, input logic bad);
    logic [7:0] f[11];
    logic [15:0] c;
    f[0] = 8'h1D;
    for (int i = 0; i < 4; i++) f[1 + i] = id[31 - 8 * i -: 8];
    for (int i = 0; i < 4; i++) f[5 + i] = prm[31 - 8 * i -: 8];
    c = 16'hFFFF;
    for (int i = 0; i < 9; i++) begin
      c = c ^ {8'h00, f[i]};
      for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
    end
    c = ~c ^ {15'h0000, bad};
    f[9] = c[7:0];
    f[10] = c[15:8];
    for (int i = 0; i < 11; i++) begin
      @(posedge clock);
      rxValid <= 1'b1;
      rxData <= f[i];
    end
    @(posedge clock);
    rxValid <= 1'b0;
    rxData <= ~f[10];
    rxEnd <= 1'b1;
    @(posedge clock);
    rxEnd <= 1'b0;
  endtask
endmodule

// >>> verif/rfat_attrib_handler_chk.sv
// Purpose: Port-level timing and framing checks of the ATTRIB handler.
// Assumes: Single clock domain, reset active low.
// Notes: Answer bytes are 10h, F9h, E0h.
module rfat_attrib_handler_chk #(
  parameter int TR1_CYCLES = 4
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic rxEnd,
  input wire logic subcarrierOn,
  input wire logic txValid,
  input wire logic [7:0] txData,
  input wire logic txLast,
  input wire logic txReady,
  input wire logic txSofEnable,
  input wire logic txEofEnable,
  input wire logic [1:0] linkRate,
  input wire logic cmdEnabled
);
  localparam int TR1_LO = TR1_CYCLES - 1;
  localparam int TR1_HI = TR1_CYCLES + 1;
  logic [12:0] sinceEnd;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // Cycles since the last frame end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) sinceEnd <= 13'h1FFF;
    else if (rxEnd) sinceEnd <= 13'h0000;
    else if (sinceEnd != 13'h1FFF) sinceEnd <= sinceEnd + 13'h0001;
  end
  frame_marks_a: assert property (txSofEnable && txEofEnable)
    else $error("frame marker disabled");
  tr0_delay_a: assert property ($rose(subcarrierOn) |-> sinceEnd inside {[13'h0EBD:13'h0EBF]})
    else $error("response delay wrong");
  tr1_delay_a: assert property ($rose(subcarrierOn) |-> ##[TR1_LO:TR1_HI] $rose(txValid))
    else $error("subcarrier to data time wrong");
  tx_hold_a: assert property (txValid && !txReady |=> txValid && $stable(txData))
    else $error("answer byte not held");
  resp_code_a: assert property ($rose(txValid) |-> txData == 8'h10)
    else $error("first answer byte wrong");
  crc_bytes_a: assert property ($rose(txLast) |-> txData == 8'hE0 && $past(txData) == 8'hF9)
    else $error("answer check bytes wrong");
  tx_end_a: assert property (txLast && txReady |=> !txValid && !txLast && !subcarrierOn)
    else $error("answer not closed after third byte");
  tx_carrier_a: assert property (txValid |-> subcarrierOn)
    else $error("data sent without subcarrier");
  accept_edge_a: assert property ($rose(cmdEnabled) |-> $past(rxEnd))
    else $error("enabled state entered without frame end");
  rate_set_a: assert property (!$stable(linkRate) |-> $past(rxEnd) && linkRate <= 2'h1)
    else $error("link rate changed wrongly");
  cover property ($rose(cmdEnabled));
  cover property (txValid && !txReady);
  cover property (txLast && txReady);
endmodule

bind rfat_attrib_handler rfat_attrib_handler_chk #(.TR1_CYCLES(TR1_CYCLES)) i_chk (
  .clock(clock), .rst_n(rst_n), .rxEnd(rxEnd), .subcarrierOn(subcarrierOn),
  .txValid(txValid), .txData(txData), .txLast(txLast), .txReady(txReady),
  .txSofEnable(txSofEnable), .txEofEnable(txEofEnable), .linkRate(linkRate),
  .cmdEnabled(cmdEnabled)
);

// >>> verif/tb_top.sv
// Purpose: Self-checking bench for the ATTRIB handler.
// Assumes: 50 MHz clock; short subcarrier-to-data time of 4 cycles.
// Notes: Each frame is followed by status and counter reads.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rfat_pkg::*;
  localparam logic [31:0] P = 32'h5A3C_0F96;
  logic clock, rst_n, avs_read, avs_write, avs_waitrequest, stall;
  logic rxValid, rxEnd, subcarrierOn, txValid, txLast, txReady;
  logic txSofEnable, txEofEnable, cmdEnabled;
  logic [1:0] linkRate;
  logic [3:0] avs_address, avs_byteenable;
  logic [7:0] rxData, txData, acc, rej;
  logic [31:0] avs_writedata, avs_readdata, rd, curStat;
  int nMismatch, checkCount;
  rfat_attrib_handler #(.TR1_CYCLES(4)) i_dut (
    .clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rxValid(rxValid),
    .rxData(rxData), .rxEnd(rxEnd), .subcarrierOn(subcarrierOn), .txValid(txValid),
    .txData(txData), .txLast(txLast), .txReady(txReady), .txSofEnable(txSofEnable),
    .txEofEnable(txEofEnable), .linkRate(linkRate), .cmdEnabled(cmdEnabled)
  );
  rfat_pcd_model i_pcd (
    .clock(clock), .stall(stall), .txValid(txValid), .txData(txData), .rxValid(rxValid),
    .rxData(rxData), .rxEnd(rxEnd), .txReady(txReady)
  );
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic giveVerdict();
    if (nMismatch == 0 && checkCount > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp) begin
      nMismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic busOp(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    @(posedge clock);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rdChk(input logic [3:0] a, input logic [31:0] exp);
    busOp(1'b0, a, 32'h0000_0000);
    cmp("register", exp, rd);
  endtask
  function automatic logic [31:0] stat(input logic [7:0] p1, input logic [7:0] p2);
    logic [1:0] t0, t1;
    t0 = p1[7:6] == 2'h3 ? 2'h0 : p1[7:6];
    t1 = p1[5:4] == 2'h3 ? 2'h0 : p1[5:4];
    return {21'h000000, t1, t0, p2[3:0], p2[7:6], 1'b1};
  endfunction
  task automatic frame(input logic [31:0] id, input logic [31:0] prm, input logic bad,
                       input logic ok);
    i_pcd.got.delete();
    i_pcd.send(id, prm, bad);
    if (ok) begin
      curStat = stat(prm[31:24], prm[23:16]);
      acc++;
      rdChk(REG_STATUS, curStat | 32'h0000_0800);
      for (int i = 0; i < 5000 && i_pcd.got.size() < 3; i++) @(posedge clock);
      cmp("byte0", 32'h10, i_pcd.got[0]);
      cmp("byte1", 32'hF9, i_pcd.got[1]);
      cmp("byte2", 32'hE0, i_pcd.got[2]);
    end else begin
      repeat (4000) @(posedge clock);
      rej++;
    end
    cmp("bytes", ok ? 3 : 0, i_pcd.got.size());
    cmp("linkRate", {30'h0, curStat[2:1]}, {30'h0, linkRate});
    cmp("cmdEnabled", {31'h0, curStat[0]}, {31'h0, cmdEnabled});
    rdChk(REG_STATUS, curStat);
    rdChk(REG_COUNT, {16'h0000, rej, acc});
  endtask
  initial begin
    nMismatch = 0;
    checkCount = 0;
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hF;
    stall = 1'b0;
    acc = 8'h00;
    rej = 8'h00;
    curStat = 32'h0000_0040;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    rdChk(REG_CTRL, 32'h0000_0001);
    rdChk(REG_PUPI, 32'h0000_0000);
    rdChk(REG_STATUS, curStat);
    rdChk(REG_COUNT, 32'h0000_0000);
    busOp(1'b1, REG_PUPI, P);
    busOp(1'b1, REG_STATUS, 32'hFFFF_FFFF);
    rdChk(REG_PUPI, P);
    avs_byteenable <= 4'h2;
    busOp(1'b1, REG_PUPI, 32'h0000_0000);
    avs_byteenable <= 4'hF;
    rdChk(REG_PUPI, P & 32'hFFFF_00FF);
    busOp(1'b1, REG_PUPI, P);
    rdChk(REG_STATUS, curStat);
    rdChk(4'h2, 32'h0000_0000);
    frame(P ^ 32'h1, 32'h0008_0100, 1'b0, 1'b0);
    frame(P, 32'h0008_0100, 1'b1, 1'b0);
    frame(P, 32'h0048_0100, 1'b0, 1'b0);
    frame(P, 32'h00A8_0100, 1'b0, 1'b0);
    frame(P, 32'h0004_0100, 1'b0, 1'b0);
    frame(P, 32'h0009_0100, 1'b0, 1'b0);
    frame(P, 32'h0008_1100, 1'b0, 1'b0);
    frame(P, 32'h0008_0200, 1'b0, 1'b0);
    frame(P, 32'h0008_0101, 1'b0, 1'b0);
    stall <= 1'b1;
    frame(P, 32'hFF55_01F0, 1'b0, 1'b1);
    stall <= 1'b0;
    frame(P, 32'h6407_0100, 1'b0, 1'b1);
    frame(P, 32'h1056_0100, 1'b0, 1'b1);
    frame(P, 32'h0008_0100, 1'b0, 1'b1);
    busOp(1'b1, REG_CTRL, 32'h0000_0003);
    curStat[0] = 1'b0;
    rdChk(REG_STATUS, curStat);
    rdChk(REG_CTRL, 32'h0000_0001);
    busOp(1'b1, REG_CTRL, 32'h0000_0000);
    rdChk(REG_CTRL, 32'h0000_0000);
    frame(P, 32'h0008_0100, 1'b0, 1'b0);
    giveVerdict();
  end
  initial begin
    repeat (90000) @(posedge clock);
    nMismatch++;
    giveVerdict();
  end
endmodule
